// [rtl/ace_pkg.sv]
// Constants, register layout and carrier types for the comparator event control block
// Contract
// - Enable bit 15 turns the comparator on; zero keeps it off.
// - Output-enable bit 14 drives the result onto the external pin.
// - Invert bit 13 inverts the output; the readable result shows it.
// - Sticky event flag bit 9 sets on an event, blocks triggers until cleared.
// - Select 11 gives trigger, event and interrupt on any output change.
// - Select 10 gives an event on a falling polarity-adjusted output.
// - Select 01 gives an event on a rising polarity-adjusted output.
// - Select 00 gives no trigger, event or interrupt; the change interrupt status bit still sets on any output change.
// - Bit 4 picks internal reference or external positive pin for the plus input.
// - Bits 1-0 pick the minus input: external pin or three channel outputs.
// - A selected input missing from the package is tied to ground.
// - Unimplemented control bits read zero and ignore writes.
package ace_pkg;

  localparam int ACE_AW = 12;
  localparam logic [ACE_AW-1:0] ACE_SETTINGS_ADDR = 12'h000;
  localparam logic [ACE_AW-1:0] ACE_IRQ_STATUS_ADDR = 12'h004;
  localparam logic [ACE_AW-1:0] ACE_IRQ_MASK_ADDR = 12'h008;

  localparam int ACE_ON_BIT = 15;
  localparam int ACE_OE_BIT = 14;
  localparam int ACE_INV_BIT = 13;
  localparam int ACE_EVT_BIT = 9;
  localparam int ACE_RES_BIT = 8;
  localparam int ACE_EDGE_LSB = 6;
  localparam int ACE_REF_BIT = 4;
  localparam int ACE_CH_LSB = 0;

  // Writable bits of the settings word; bit 8 is read-only and the rest are unimplemented
  localparam logic [15:0] ACE_SETTINGS_WMASK = 16'hE2D3;
  localparam logic [15:0] ACE_SETTINGS_RESET = 16'h0000;

  localparam logic [1:0] ACE_EDGE_OFF = 2'h0;
  localparam logic [1:0] ACE_EDGE_RISE = 2'h1;
  localparam logic [1:0] ACE_EDGE_FALL = 2'h2;
  localparam logic [1:0] ACE_EDGE_ANY = 2'h3;

  localparam logic [1:0] ACE_IRQ_RESET = 2'h0;
  localparam int ACE_IRQ_EVENT = 0;
  localparam int ACE_IRQ_CHANGE = 1;

  typedef struct packed {
    logic comparator_on;
    logic output_invert;
    logic positive_ref_select;
    logic [1:0] negative_channel_select;
  } ace_analog_cfg_t;

  typedef struct packed {
    logic external_result_pin;
    logic external_result_pin_oe;
  } ace_pin_t;

endpackage

// [rtl/ace_comparator_event_control.sv]
// Comparator event control: APB settings register, event detect, interrupt
`timescale 1ns/100ps
module ace_comparator_event_control
  import ace_pkg::*;
#(
  parameter logic [3:0] INPUT_AVAILABLE = 4'hF,
  parameter logic POSITIVE_PIN_AVAILABLE = 1'b1,
  parameter logic INTERNAL_REF_AVAILABLE = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_compare,
  output ace_analog_cfg_t analog_cfg,
  output logic positive_tie_ground,
  output logic negative_tie_ground,
  output ace_pin_t result_pin,
  output logic compare_trigger,
  output logic irq
);

  logic [15:0] settings;
  logic [15:0] next_settings;
  logic [1:0] irq_status;
  logic [1:0] next_irq_status;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic sync_a;
  logic sync_b;
  logic prev_result;
  logic [31:0] next_prdata;
  logic trig_q;
  logic next_trig;

  logic wr_en;
  logic rd_en;
  logic hit_settings;
  logic hit_status;
  logic hit_mask;
  logic compare_result;
  logic rise;
  logic fall;
  logic edge_hit;
  logic [1:0] edge_sel;
  logic [15:0] wmask16;

  assign pready = 1'b1;
  assign hit_settings = (paddr[ACE_AW-1:0] == ACE_SETTINGS_ADDR);
  assign hit_status = (paddr[ACE_AW-1:0] == ACE_IRQ_STATUS_ADDR);
  assign hit_mask = (paddr[ACE_AW-1:0] == ACE_IRQ_MASK_ADDR);
  assign pslverr = psel && penable && !(hit_settings || hit_status || hit_mask);
  assign wr_en = psel && penable && pwrite && !pslverr;
  assign rd_en = psel && !penable && !pwrite;
  assign wmask16 = {{8{pstrb[1]}}, {8{pstrb[0]}}} & ACE_SETTINGS_WMASK;

  // Polarity applied after the synchroniser; result is gated off while disabled
  assign compare_result = settings[ACE_ON_BIT] & (sync_b ^ settings[ACE_INV_BIT]);
  assign rise = compare_result && !prev_result;
  assign fall = !compare_result && prev_result;
  assign edge_sel = settings[ACE_EDGE_LSB +: 2];

  always_comb
  begin
    case (edge_sel)
      ACE_EDGE_RISE: edge_hit = rise;
      ACE_EDGE_FALL: edge_hit = fall;
      ACE_EDGE_ANY: edge_hit = rise || fall;
      ACE_EDGE_OFF: edge_hit = 1'b0;
      default: edge_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_settings = settings;
    if (wr_en && hit_settings)
    begin
      next_settings = (settings & ~wmask16) | (pwdata[15:0] & wmask16);
    end
    // Event set wins over a simultaneous software clear; flag blocks retriggers
    next_trig = edge_hit && !settings[ACE_EVT_BIT];
    if (next_trig)
    begin
      next_settings[ACE_EVT_BIT] = 1'b1;
    end
    next_settings[ACE_RES_BIT] = compare_result;
  end

  always_comb
  begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (wr_en && hit_status && pstrb[0])
    begin
      next_irq_status = irq_status & ~pwdata[1:0];
    end
    if (wr_en && hit_mask && pstrb[0])
    begin
      next_irq_mask = pwdata[1:0];
    end
    if (next_trig)
    begin
      next_irq_status[ACE_IRQ_EVENT] = 1'b1;
    end
    if (rise || fall)
    begin
      next_irq_status[ACE_IRQ_CHANGE] = 1'b1;
    end
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (rd_en)
    begin
      if (hit_settings)
      begin
        next_prdata = {16'h0000, settings};
      end
      else if (hit_status)
      begin
        next_prdata = {30'h0000_0000, irq_status};
      end
      else if (hit_mask)
      begin
        next_prdata = {30'h0000_0000, irq_mask};
      end
    end
    else if (psel && penable)
    begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      settings <= ACE_SETTINGS_RESET;
      irq_status <= ACE_IRQ_RESET;
      irq_mask <= ACE_IRQ_RESET;
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev_result <= 1'b0;
      prdata <= 32'h0000_0000;
      trig_q <= 1'b0;
    end
    else
    begin
      settings <= next_settings;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      sync_a <= raw_compare;
      sync_b <= sync_a;
      prev_result <= compare_result;
      prdata <= next_prdata;
      trig_q <= next_trig;
    end
  end

  // Missing package inputs become ground at the analog mux
  always_comb
  begin
    analog_cfg.comparator_on = settings[ACE_ON_BIT];
    analog_cfg.output_invert = settings[ACE_INV_BIT];
    analog_cfg.positive_ref_select = settings[ACE_REF_BIT];
    analog_cfg.negative_channel_select = settings[ACE_CH_LSB +: 2];
    positive_tie_ground = settings[ACE_REF_BIT] ? !INTERNAL_REF_AVAILABLE
                                                : !POSITIVE_PIN_AVAILABLE;
    negative_tie_ground = !INPUT_AVAILABLE[settings[ACE_CH_LSB +: 2]];
    result_pin.external_result_pin = settings[ACE_RES_BIT];
    result_pin.external_result_pin_oe = settings[ACE_OE_BIT];
  end

  assign compare_trigger = trig_q;
  assign irq = |(irq_status & irq_mask);

endmodule // ace_comparator_event_control

// [tb/ace_asserts.sv]
// Port checker for the comparator event control block
`timescale 1ns/100ps
module ace_asserts
  import ace_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire ace_analog_cfg_t analog_cfg,
  input wire ace_pin_t result_pin,
  input wire logic compare_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = psel && penable && paddr == 32'h0;
  wire logic hi = acc && pwrite && pstrb[1];
  wire logic lo = acc && pwrite && pstrb[0];
  property p_on; hi |=> analog_cfg.comparator_on == $past(pwdata[15]); endproperty
  a_on: assert property (p_on) else $error("enable wrong");
  property p_oe; hi |=> result_pin.external_result_pin_oe == $past(pwdata[14]); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_inv; hi |=> analog_cfg.output_invert == $past(pwdata[13]); endproperty
  a_inv: assert property (p_inv) else $error("invert wrong");
  property p_ref; lo |=> analog_cfg.positive_ref_select == $past(pwdata[4]); endproperty
  a_ref: assert property (p_ref) else $error("ref select wrong");
  property p_ch; lo |=> analog_cfg.negative_channel_select == $past(pwdata[1:0]); endproperty
  a_ch: assert property (p_ch) else $error("channel wrong");
  // Bit 8 is readable, so only truly unused bits must be zero
  property p_rd; acc && !pwrite |-> (prdata & 32'hFFFF1C2C) == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("unused bits set");
  property p_pulse; compare_trigger |=> !compare_trigger; endproperty
  a_pulse: assert property (p_pulse) else $error("second trigger");
  property p_rst; $rose(rst_n) |-> analog_cfg == 5'h0 && !result_pin.external_result_pin_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_trig: cover property (compare_trigger);
  c_hi: cover property (hi);
  c_rd: cover property (acc && !pwrite);
endmodule // ace_asserts

// [tb/ace_comp_model.sv]
// Behavioural analog comparator core for the bench
`timescale 1ns/100ps
module ace_comp_model
  import ace_pkg::*;
(
  input wire ace_analog_cfg_t analog_cfg,
  input wire logic vin_above,
  output logic raw_compare
);
  // A core that is off gives a steady low
  assign raw_compare = analog_cfg.comparator_on & vin_above;
endmodule // ace_comp_model

// [tb/tb_top.sv]
// Bench top: APB master, scenarios and verdict
`timescale 1ns/100ps
module tb_top
  import ace_pkg::*;
;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic vin_above = 1'h0, pready, pslverr, raw_compare, irq, er, compare_trigger;
  logic positive_tie_ground, negative_tie_ground;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  ace_analog_cfg_t analog_cfg;
  ace_pin_t result_pin;
  int errors = 0, comparisons = 0, trig = 0;
  ace_comparator_event_control i_ace_comparator_event_control (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .raw_compare,
    .analog_cfg, .positive_tie_ground, .negative_tie_ground, .result_pin,
    .compare_trigger, .irq);
  ace_comp_model i_ace_comp_model (.analog_cfg, .vin_above, .raw_compare);
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (compare_trigger === 1'h1) trig <= trig + 1;
  task results;
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
    errors += (s !== e);
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do @(posedge clk) n++; while (pready !== 1'h1 && n < 20);
    rd = prdata; er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    errors += (n >= 20);
    if (n >= 20) results();
  endtask
  task t_reset;
    apb(1'h0, 32'h0, 32'h0); chk("settings", rd, 32'h0);
    apb(1'h0, 32'hC, 32'h0); chk("unmapped", er, 32'h1);
    apb(1'h1, 32'h8, 32'h1);
  endtask
  task t_cfg;
    apb(1'h1, 32'h0, 32'hFD3F);
    repeat (4) @(posedge clk);
    apb(1'h0, 32'h0, 32'h0); chk("settings", rd, 32'hE113);
    chk("cfg", analog_cfg, 32'h1F);
    chk("oe", result_pin.external_result_pin_oe, 32'h1);
    chk("tie", {positive_tie_ground, negative_tie_ground}, 32'h0);
    chk("ready", pready, 32'h1);
  endtask
  task ev(input logic [1:0] m, input logic inv);
    logic ra, fa;
    int t0;
    ra = m == 2'h3 || (m == 2'h1 && !inv) || (m == 2'h2 && inv);
    // Sticky flag blocks the fall once the rise was taken
    fa = !ra && ((m == 2'h2 && !inv) || (m == 2'h1 && inv));
    // Interrupt enable stays off while the edge select is changed
    apb(1'h1, 32'h8, 32'h0);
    apb(1'h1, 32'h0, {16'h0, 2'h2, inv, 13'h0});
    repeat (4) @(posedge clk);
    apb(1'h1, 32'h0, {16'h0, 2'h2, inv, 5'h0, m, 6'h0});
    apb(1'h1, 32'h4, 32'h3);
    apb(1'h1, 32'h8, 32'h1);
    t0 = trig;
    vin_above <= 1'h1;
    repeat (6) @(posedge clk);
    chk("rise", trig - t0, ra);
    chk("pin", result_pin.external_result_pin, !inv);
    chk("irq", irq, ra);
    apb(1'h0, 32'h0, 32'h0); chk("flag", rd[9], ra);
    t0 = trig;
    vin_above <= 1'h0;
    repeat (6) @(posedge clk);
    chk("fall", trig - t0, fa);
    apb(1'h1, 32'h4, 32'h3);
    @(posedge clk);
    chk("irq clear", irq, 32'h0);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    t_reset;
    t_cfg;
    for (int i = 0; i < 8; i++) ev(i[1:0], i[2]);
    results();
  end
endmodule // tb_top
bind ace_comparator_event_control ace_asserts i_ace_asserts (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .analog_cfg, .result_pin, .compare_trigger);
